// ==== design/ncr_pkg.sv ====
// package: constants, field layout and state types of the command register block
package ncr_pkg;

    // register map: the command register sits at offset 0 of every page
    localparam logic [3:0] CMD_OFFSET   = 4'h0;

    // command register field positions
    localparam int         HALT_POS     = 0;
    localparam int         ACT_POS      = 1;
    localparam int         TXGO_POS     = 2;
    localparam int         RCMD_LSB     = 3;
    localparam int         RCMD_MSB     = 5;
    localparam int         PAGE_LSB     = 6;
    localparam int         PAGE_MSB     = 7;

    // values after reset
    localparam logic       HALT_RST     = 1'b1;
    localparam logic       ACT_RST      = 1'b0;
    localparam logic       TXGO_RST     = 1'b0;
    localparam logic [2:0] RCMD_RST     = 3'h4;
    localparam logic [1:0] PAGE_RST     = 2'h0;

    // remote command encodings
    localparam logic [2:0] RCMD_NONE    = 3'h0;
    localparam logic [2:0] RCMD_READ    = 3'h1;
    localparam logic [2:0] RCMD_WRITE   = 3'h2;
    localparam logic [2:0] RCMD_SEND    = 3'h3;
    localparam logic [2:0] RCMD_ABORT   = 3'h4;

    // page select encodings
    localparam logic [1:0] PAGE_0       = 2'h0;
    localparam logic [1:0] PAGE_1       = 2'h1;
    localparam logic [1:0] PAGE_2       = 2'h2;
    localparam logic [1:0] PAGE_RSVD    = 2'h3;

    // depth of every pin synchroniser
    localparam int         SYNC_STAGES  = 2;

    // run state of the controller, one-hot
    typedef enum logic [2:0] {
        NCR_RUN    = 3'b001,
        NCR_DRAIN  = 3'b010,
        NCR_HALTED = 3'b100
    } ncr_run_t;

endpackage

// ==== design/ncr_rdma_if.sv ====
// interface: command decode to remote dma tracker signals
`timescale 1ns/1ns
interface ncr_rdma_if;
    logic       cmd_wr;        // one-cycle pulse: command register written
    logic [2:0] cmd_code;      // remote command field as written
    logic       cmd_txgo;      // transmit go bit as written
    logic       count_zero;    // remote byte count reached zero
    logic       count_loaded;  // remote byte count was reloaded
    logic       ack;           // synchronised read or write acknowledge edge
    logic       busy;          // remote dma active
    logic       done;          // pulse: remote dma finished or cut short
    logic       start;         // pulse: remote dma started
    logic       abort;         // pulse: remote dma aborted
    logic [2:0] mode;          // active remote command
    logic       port_request;  // port request level

    // command decode side
    modport ctrl (
        output cmd_wr, cmd_code, cmd_txgo, count_zero, count_loaded, ack,
        input  busy, done, start, abort, mode, port_request
    );

    // tracker side
    modport track (
        input  cmd_wr, cmd_code, cmd_txgo, count_zero, count_loaded, ack,
        output busy, done, start, abort, mode, port_request
    );
endinterface

// ==== design/ncr_rdma_track.sv ====
// module: remote dma command tracker with port request handling
`timescale 1ns/1ns
module ncr_rdma_track (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // link to command decode
    ncr_rdma_if.track rd_if
);

    // all tracker state
    typedef struct packed {
        logic       busy;       // remote dma running
        logic [2:0] mode;       // running command
        logic       reloaded;   // count reloaded since start
        logic       port_req;   // port request level
        logic       done;       // completion pulse
        logic       start;      // start pulse
        logic       abort;      // abort pulse
    } ncr_trk_t;

    ncr_trk_t trk_reg;   // registered state
    ncr_trk_t trk_next;  // next state

    // next-state logic
    always_comb begin
        trk_next       = trk_reg;
        trk_next.done  = 1'b0;
        trk_next.start = 1'b0;
        trk_next.abort = 1'b0;
        // byte count exhausted ends the operation
        if (trk_reg.busy && rd_if.count_zero) begin
            trk_next.busy     = 1'b0;
            trk_next.port_req = 1'b0;
            trk_next.done     = 1'b1;
        end
        // acknowledge after an abort drops a stuck request
        if (!trk_reg.busy && rd_if.ack) begin
            trk_next.port_req = 1'b0;
        end
        if (rd_if.cmd_wr) begin
            if (rd_if.cmd_code[2]) begin
                // abort: busy drops, request stays up
                if (trk_reg.busy) begin
                    trk_next.busy  = 1'b0;
                    trk_next.abort = 1'b1;
                    trk_next.done  = 1'b1;
                end
            end else if (rd_if.cmd_code != ncr_pkg::RCMD_NONE) begin
                if (trk_reg.busy && rd_if.cmd_txgo && rd_if.cmd_code == trk_reg.mode) begin
                    // reissue with transmit: finish now unless count was reloaded
                    if (!trk_reg.reloaded) begin
                        trk_next.busy     = 1'b0;
                        trk_next.port_req = 1'b0;
                        trk_next.done     = 1'b1;
                    end
                end else if (!(trk_reg.busy && rd_if.cmd_code == trk_reg.mode)) begin
                    // fresh command
                    trk_next.busy     = 1'b1;
                    trk_next.mode     = rd_if.cmd_code;
                    trk_next.port_req = 1'b1;
                    trk_next.start    = 1'b1;
                    trk_next.reloaded = 1'b0;
                end
            end
        end
        // a reload in the same cycle as a start still counts
        if (rd_if.count_loaded) begin
            trk_next.reloaded = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            trk_reg <= '0;
        end else begin
            trk_reg <= trk_next;
        end
    end

    // outputs
    assign rd_if.busy         = trk_reg.busy;
    assign rd_if.mode         = trk_reg.mode;
    assign rd_if.port_request = trk_reg.port_req;
    assign rd_if.done         = trk_reg.done;
    assign rd_if.start        = trk_reg.start;
    assign rd_if.abort        = trk_reg.abort;

endmodule

// ==== design/ncr_command.sv ====
// module: command register, run control, transmit go and page select
`timescale 1ns/1ns
module ncr_command (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    // parallel register port pins
    input  wire logic       cs_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    // remote dma acknowledge pins
    input  wire logic       read_ack,
    input  wire logic       write_ack,
    output logic            port_request,
    // controller status, same clock
    input  wire logic       rx_busy,
    input  wire logic       tx_busy,
    input  wire logic       tx_done,
    input  wire logic       tx_abort,
    input  wire logic       rdma_count_zero,
    input  wire logic       rdma_count_loaded,
    // controller steering
    output logic            online,
    output logic            reset_done_set,
    output logic            tx_start,
    output logic      [1:0] page_sel,
    output logic      [3:0] page_reg_addr,
    output logic      [2:0] rdma_mode,
    output logic            rdma_busy,
    output logic            rdma_start,
    output logic            rdma_abort
);

    // all state of the decode
    typedef struct packed {
        logic [1:0]      cs_n_s;     // chip select synchroniser
        logic [1:0]      rd_n_s;     // read strobe synchroniser
        logic [1:0]      wr_n_s;     // write strobe synchroniser
        logic [1:0]      read_ack_s;     // read acknowledge synchroniser
        logic [1:0]      write_ack_s;     // write acknowledge synchroniser
        logic [3:0]      addr_s0;    // address first stage
        logic [3:0]      addr_s1;    // address second stage
        logic [7:0]      data_s0;    // data first stage
        logic [7:0]      data_s1;    // data second stage
        logic            wr_n_d;     // delayed write strobe for edge
        logic            cs_n_d;     // chip select matching the delayed strobe
        logic [3:0]      addr_d;     // address matching the delayed strobe
        logic [7:0]      data_d;     // data matching the delayed strobe
        logic            ack_d;      // previous combined acknowledge
        logic [1:0]      page;       // page select field
        logic [2:0]      rcmd;       // remote command field
        logic            txgo;       // transmit go bit
        logic            act;        // activate bit
        logic            halt;       // halt bit
        ncr_pkg::ncr_run_t run;      // run state
        logic [7:0]      dout;       // read data
        logic            doe;        // read data enable
        logic            tx_start;   // transmit start pulse
        logic            rst_done;   // reset done pulse
    } ncr_state_t;

    ncr_state_t st_reg;    // registered state
    ncr_state_t st_next;   // next state

    ncr_rdma_if rd_if ();  // link to the remote dma tracker

    logic       wr_take;   // write strobe released on the command register
    logic       rd_live;   // host is reading the command register
    logic [7:0] wdata;     // data of the write being taken
    logic [7:0] cmd_view;  // live command register image
    logic       ack_now;   // combined synchronised acknowledge

    // remote dma tracker
    ncr_rdma_track u_track (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .rd_if   (rd_if)
    );

    // strobe decode from second synchroniser stages and their delayed copies only
    always_comb begin
        wr_take = st_reg.wr_n_s[1] && !st_reg.wr_n_d && !st_reg.cs_n_d
                  && st_reg.addr_d == ncr_pkg::CMD_OFFSET;
        rd_live = !st_reg.cs_n_s[1] && !st_reg.rd_n_s[1]
                  && st_reg.addr_s1 == ncr_pkg::CMD_OFFSET;
        wdata   = st_reg.data_d;
        ack_now = st_reg.read_ack_s[1] || st_reg.write_ack_s[1];
    end

    // live image of the command register
    always_comb begin
        cmd_view                                       = 8'h00;
        cmd_view[ncr_pkg::PAGE_MSB:ncr_pkg::PAGE_LSB] = st_reg.page;
        cmd_view[ncr_pkg::RCMD_MSB:ncr_pkg::RCMD_LSB] = st_reg.rcmd;
        cmd_view[ncr_pkg::TXGO_POS]                   = st_reg.txgo;
        cmd_view[ncr_pkg::ACT_POS]                    = st_reg.act;
        cmd_view[ncr_pkg::HALT_POS]                   = st_reg.halt;
    end

    // commands handed to the tracker
    assign rd_if.cmd_wr       = wr_take;
    assign rd_if.cmd_code     = wdata[ncr_pkg::RCMD_MSB:ncr_pkg::RCMD_LSB];
    assign rd_if.cmd_txgo     = wdata[ncr_pkg::TXGO_POS];
    assign rd_if.count_zero   = rdma_count_zero;
    assign rd_if.count_loaded = rdma_count_loaded;
    assign rd_if.ack          = ack_now && !st_reg.ack_d;

    // next-state logic
    always_comb begin
        st_next          = st_reg;
        st_next.tx_start = 1'b0;
        st_next.rst_done = 1'b0;

        // pin synchronisers: first stage feeds only the second
        st_next.cs_n_s  = {st_reg.cs_n_s[0], cs_n};
        st_next.rd_n_s  = {st_reg.rd_n_s[0], rd_n};
        st_next.wr_n_s  = {st_reg.wr_n_s[0], wr_n};
        st_next.read_ack_s  = {st_reg.read_ack_s[0], read_ack};
        st_next.write_ack_s  = {st_reg.write_ack_s[0], write_ack};
        st_next.addr_s0 = reg_addr;
        st_next.addr_s1 = st_reg.addr_s0;
        st_next.data_s0 = data_in;
        st_next.data_s1 = st_reg.data_s0;
        st_next.wr_n_d  = st_reg.wr_n_s[1];
        st_next.cs_n_d  = st_reg.cs_n_s[1];
        st_next.addr_d  = st_reg.addr_s1;
        st_next.data_d  = st_reg.data_s1;
        st_next.ack_d   = ack_now;

        // remote dma end shows as the abort/complete code
        if (rd_if.done) begin
            st_next.rcmd = ncr_pkg::RCMD_ABORT;
        end

        // transmission finished or aborted clears transmit go
        if (tx_done || tx_abort) begin
            st_next.txgo = 1'b0;
        end

        // command register write
        if (wr_take) begin
            st_next.page = wdata[ncr_pkg::PAGE_MSB:ncr_pkg::PAGE_LSB];
            st_next.halt = wdata[ncr_pkg::HALT_POS];
            // activate stays set when halting a running controller
            st_next.act  = wdata[ncr_pkg::ACT_POS]
                           || (wdata[ncr_pkg::HALT_POS] && st_reg.act);
            // the all-zero remote code is not a command; it keeps the field
            if (wdata[ncr_pkg::RCMD_MSB:ncr_pkg::RCMD_LSB] != ncr_pkg::RCMD_NONE) begin
                st_next.rcmd = wdata[ncr_pkg::RCMD_MSB:ncr_pkg::RCMD_LSB];
            end
            // one starts a send while running; zero leaves it alone
            if (wdata[ncr_pkg::TXGO_POS] && st_reg.run == ncr_pkg::NCR_RUN
                && !wdata[ncr_pkg::HALT_POS]) begin
                st_next.txgo = 1'b1;
                if (!st_reg.txgo) begin
                    st_next.tx_start = 1'b1;
                end
            end
        end

        // run control
        case (st_reg.run)
            ncr_pkg::NCR_RUN: begin
                // halt request: stop taking new frames, drain current ones
                if (wr_take && wdata[ncr_pkg::HALT_POS]) begin
                    st_next.run = ncr_pkg::NCR_DRAIN;
                end
            end
            ncr_pkg::NCR_DRAIN: begin
                // frames in flight complete before the reset state
                if (!rx_busy && !tx_busy) begin
                    st_next.run      = ncr_pkg::NCR_HALTED;
                    st_next.rst_done = 1'b1;
                end
            end
            ncr_pkg::NCR_HALTED: begin
                // restart needs halt clear and activate set together
                if (wr_take && !wdata[ncr_pkg::HALT_POS] && wdata[ncr_pkg::ACT_POS]) begin
                    st_next.run = ncr_pkg::NCR_RUN;
                end
            end
            default: begin
                st_next.run = ncr_pkg::NCR_HALTED;
            end
        endcase

        // read data: command register on any page, other offsets left to other blocks
        st_next.doe  = rd_live;
        st_next.dout = rd_live ? cmd_view : 8'h00;
    end

    // state register; power-up leaves the controller halted
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_reg          <= '0;
            st_reg.cs_n_s   <= 2'h3;
            st_reg.rd_n_s   <= 2'h3;
            st_reg.wr_n_s   <= 2'h3;
            st_reg.wr_n_d   <= 1'b1;
            st_reg.cs_n_d   <= 1'b1;
            st_reg.page     <= ncr_pkg::PAGE_RST;
            st_reg.rcmd     <= ncr_pkg::RCMD_RST;
            st_reg.txgo     <= ncr_pkg::TXGO_RST;
            st_reg.act      <= ncr_pkg::ACT_RST;
            st_reg.halt     <= ncr_pkg::HALT_RST;
            st_reg.run      <= ncr_pkg::NCR_HALTED;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs
    assign data_out       = st_reg.dout;
    assign data_oe        = st_reg.doe;
    assign online         = st_reg.run == ncr_pkg::NCR_RUN;
    assign reset_done_set = st_reg.rst_done;
    assign tx_start       = st_reg.tx_start;
    assign page_sel       = st_reg.page;
    assign page_reg_addr  = st_reg.addr_s1;
    assign port_request   = rd_if.port_request;
    assign rdma_mode      = rd_if.mode;
    assign rdma_busy      = rd_if.busy;
    assign rdma_start     = rd_if.start;
    assign rdma_abort     = rd_if.abort;

endmodule

// ==== bench/ncr_command_checker.sv ====
// checker: port timing relations of the command register block
`timescale 1ns/1ns
module ncr_command_checker (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       arst_n,
    // inputs watched
    input wire logic       read_ack,
    input wire logic       write_ack,
    input wire logic       rx_busy,
    input wire logic       tx_busy,
    // outputs watched
    input wire logic       port_request,
    input wire logic       online,
    input wire logic       reset_done_set,
    input wire logic       tx_start,
    input wire logic [2:0] rdma_mode,
    input wire logic       rdma_busy,
    input wire logic       rdma_start,
    input wire logic       rdma_abort
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // a fresh acknowledge edge on either pin
    sequence ack_edge;
        $rose(read_ack) || $rose(write_ack);
    endsequence
    // request still standing on two edges in a row
    sequence held_request;
        port_request [*2];
    endsequence
    chk_tx_single: assert property (tx_start |=> !tx_start)
        else $error("tx start wider than one cycle");
    chk_tx_online: assert property (tx_start |-> online)
        else $error("tx start while offline");
    chk_done_single: assert property (reset_done_set |=> !reset_done_set)
        else $error("reset done wider than one cycle");
    chk_done_idle: assert property (reset_done_set |-> !online && !$past(rx_busy) && !$past(tx_busy))
        else $error("reset done before frames finished");
    chk_drain_wait: assert property (!online && (rx_busy || tx_busy) |=> !reset_done_set)
        else $error("reset done while a frame runs");
    chk_abort_holds: assert property (rdma_abort |-> held_request)
        else $error("port request dropped on abort");
    chk_start_request: assert property (rdma_start |=> port_request)
        else $error("no port request after dma start");
    chk_start_mode: assert property (rdma_start |-> rdma_busy && !rdma_mode[2] && rdma_mode != 3'h0)
        else $error("dma start with bad mode");
    chk_ack_release: assert property (port_request && !rdma_busy ##0 ack_edge |-> ##[1:6] !port_request)
        else $error("port request kept after acknowledge");
    chk_request_cause: assert property ($rose(port_request) |-> rdma_start)
        else $error("port request without dma start");
endmodule
bind ncr_command ncr_command_checker chk_i (.clk_sys, .arst_n, .read_ack, .write_ack, .rx_busy, .tx_busy,
    .port_request, .online, .reset_done_set, .tx_start, .rdma_mode, .rdma_busy, .rdma_start, .rdma_abort);

// ==== bench/ncr_host_model.sv ====
// partner: host processor cycles on the parallel register port
`timescale 1ns/1ns
module ncr_host_model (
    // clock
    input wire logic       clk_sys,
    // register port pins
    output logic           cs_n,
    output logic           rd_n,
    output logic           wr_n,
    output logic     [3:0] reg_addr,
    output logic     [7:0] data_in
);
    // idle bus at time zero
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        reg_addr = 4'h0;
        data_in = 8'h00;
    end
    // write: strobe low 4 edges, data kept 4 edges past release
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        cs_n = 1'b0;
        wr_n = 1'b0;
        reg_addr = a;
        data_in = d;
        repeat (4) @(posedge clk_sys);
        #1;
        wr_n = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        cs_n = 1'b1;
        data_in = ~d;  // released bus never shows the old value
        repeat (4) @(posedge clk_sys);
    endtask
    // read: strobe low long enough for the registered answer
    task rd(input logic [3:0] a);
        @(posedge clk_sys);
        #1;
        cs_n = 1'b0;
        rd_n = 1'b0;
        reg_addr = a;
        repeat (6) @(posedge clk_sys);
        #1;
        rd_n = 1'b1;
        cs_n = 1'b1;
        repeat (5) @(posedge clk_sys);
    endtask
endmodule

// ==== bench/nic_command_register_tb.sv ====
// testbench: command register block driven by a host model
`timescale 1ns/1ns
module nic_command_register_tb;
    logic        clk_sys, arst_n, cs_n, rd_n, wr_n, read_ack, write_ack, data_oe, oe_d;
    logic        rx_busy, tx_busy, tx_done, tx_abort, rdma_count_zero, rdma_count_loaded;
    logic        port_request, online, reset_done_set, tx_start, rdma_busy, rdma_start, rdma_abort;
    logic [3:0]  reg_addr, pra;
    logic [7:0]  data_in, data_out;
    logic [1:0]  page_sel, pg;
    logic [2:0]  rdma_mode;
    logic [7:0]  exp_q[$];                 // expected read answers
    logic [7:0]  n_tx = 8'h0, n_ab = 8'h0, n_rd = 8'h0;  // pulse counts
    logic [31:0] seed = 32'h2bb6;
    int          err_count = 0, checks = 0, cyc = 0;

    ncr_host_model host_i (.clk_sys, .cs_n, .rd_n, .wr_n, .reg_addr, .data_in);
    ncr_command ncr_command_i (.clk_sys, .arst_n, .cs_n, .rd_n, .wr_n, .reg_addr, .data_in, .data_out,
        .data_oe, .read_ack, .write_ack, .port_request, .rx_busy, .tx_busy, .tx_done, .tx_abort,
        .rdma_count_zero, .rdma_count_loaded, .online, .reset_done_set, .tx_start, .page_sel,
        .page_reg_addr(pra), .rdma_mode, .rdma_busy, .rdma_start, .rdma_abort);

    // xorshift source for page codes and stray writes
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    // compare one result and count it
    task chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    // verdict and end of run
    task results();
        if (err_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task wr_cmd(input logic [7:0] d);
        host_i.wr(4'h0, d);
    endtask
    // note the expected answer, then run the read cycle
    task rd_cmd(input logic [7:0] e);
        exp_q.push_back(e);
        host_i.rd(4'h0);
    endtask
    // one-cycle pulse on a same-clock status input
    task automatic pl(ref logic s);
        @(posedge clk_sys);
        #1 s = 1'b1;
        @(posedge clk_sys);
        #1 s = 1'b0;
    endtask
    // acknowledge held over the synchroniser, then settle
    task ack(input logic r);
        @(posedge clk_sys);
        #1 {read_ack, write_ack} = r ? 2'b10 : 2'b01;
        repeat (3) @(posedge clk_sys);
        #1 {read_ack, write_ack} = 2'b00;
        repeat (6) @(posedge clk_sys);
    endtask

    // clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // watcher: new read answers against oldest note, pulses counted
    always @(negedge clk_sys) begin
        if (data_oe === 1'b1 && oe_d !== 1'b1)
            chk(data_out, exp_q.pop_front());
        oe_d = data_oe;
        n_tx = n_tx + {7'h0, tx_start === 1'b1};
        n_ab = n_ab + {7'h0, rdma_abort === 1'b1};
        n_rd = n_rd + {7'h0, reset_done_set === 1'b1};
    end
    // hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            results();
        end
    end

    initial begin
        {arst_n, read_ack, write_ack, rx_busy, tx_busy, tx_done, tx_abort} = 7'h0;
        {rdma_count_zero, rdma_count_loaded} = 2'h0;
        repeat (6) @(posedge clk_sys);
        #1 arst_n = 1'b1;
        rd_cmd(8'h21);
        wr_cmd(8'h22);
        rd_cmd(8'h22);
        chk({7'h0, online}, 8'h01);
        // random pages, stray writes to other offsets are ignored
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            pg = seed[1:0];
            wr_cmd({pg, 6'h22});
            rd_cmd({pg, 6'h22});
            chk({6'h0, page_sel}, {6'h0, pg});
            host_i.wr(seed[11:8] | 4'h1, seed[23:16]);
            chk({4'h0, pra}, {4'h0, seed[11:8] | 4'h1});
            rd_cmd({pg, 6'h22});
        end
        wr_cmd(8'h22);
        // transmit with a zero write overlapping it
        #1 tx_busy = 1'b1;
        wr_cmd(8'h26);
        rd_cmd(8'h26);
        wr_cmd(8'h22);
        rd_cmd(8'h26);
        pl(tx_done);
        tx_busy = 1'b0;
        rd_cmd(8'h22);
        // remote read finishing on count zero
        wr_cmd(8'h0a);
        chk({7'h0, rdma_busy}, 8'h01);
        chk({5'h0, rdma_mode}, 8'h01);
        chk({7'h0, port_request}, 8'h01);
        pl(rdma_count_zero);
        repeat (3) @(posedge clk_sys);
        chk({7'h0, port_request}, 8'h00);
        rd_cmd(8'h22);
        // each remote code aborted, request cleared by acknowledge
        for (int k = 1; k < 4; k++) begin
            wr_cmd({2'b00, k[2:0], 3'b010});
            rd_cmd({2'b00, k[2:0], 3'b010});
            wr_cmd(8'h22);
            chk({7'h0, port_request}, 8'h01);
            ack(k[0]);
            chk({7'h0, port_request}, 8'h00);
        end
        // remote write reissued with transmit after a reload keeps running
        wr_cmd(8'h12);
        pl(rdma_count_loaded);
        wr_cmd(8'h16);
        chk({7'h0, port_request}, 8'h01);
        pl(rdma_count_zero);
        pl(tx_abort);
        // remote write reissued with transmit and no reload
        wr_cmd(8'h12);
        wr_cmd(8'h16);
        chk({7'h0, port_request}, 8'h00);
        rd_cmd(8'h26);
        pl(tx_abort);
        rd_cmd(8'h22);
        // halt while a frame is still arriving
        #1 rx_busy = 1'b1;
        wr_cmd(8'h21);
        chk({7'h0, online}, 8'h00);
        rd_cmd(8'h23);
        chk(n_rd, 8'h00);
        #1 rx_busy = 1'b0;
        repeat (4) @(posedge clk_sys);
        chk(n_rd, 8'h01);
        wr_cmd(8'h22);
        rd_cmd(8'h22);
        chk(n_tx, 8'h03);
        chk(n_ab, 8'h03);
        results();
    end
endmodule
